// ===== rtl/cmb_msg_buf.sv
// receive FIFO, transmit buffers and scheduler with Avalon-MM register access
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps

// Notes on behaviour
// - transmit pin low means dominant, high means recessive.
// - receive path is background buffer then CPU-visible foreground buffer.
// - each receive buffer stores 13 bytes of control, identifier, data.
// - receive-full flag set when foreground holds a good accepted frame.
// - frame lands in background; accepted copies to foreground if flag clear.
// - background overwritten by every new frame regardless of filter, except while it holds a frame waiting for the foreground.
// - own transmitted frame stays in background, no flag, no ack.
// - loop-back treats own frames like any other received frame.
// - after lost arbitration the winning frame is received normally.
// - accepted frame with both buffers full is dropped, overrun raised.
// - with both buffers full, transmit continues, incoming frames dropped.
// - three transmit buffers, each 13 bytes like a receive buffer.
// - each transmit buffer has a software-written 8-bit local priority.
// - successful send sets the buffer's empty flag and transmit interrupt.
// - among ready buffers the smallest priority value goes first.
// - selection rerun at every arbitration, also after an error.
// - abort of a pending buffer sets acknowledge and empty flags.
// - a buffer under transmission is not aborted; acknowledge stays clear.
// - flags cleared by writing one; not cleared while cause persists.
// - receive interrupt raised right after end of an accepted frame.
// - transmit pin held recessive in any low-power mode.
module cmb_msg_buf (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [cmb_pkg::CMB_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic bus_rx_pin,
    output logic bus_tx_pin,
    input wire logic eng_tx_bit,
    output logic eng_rx_bit,
    output logic eng_ack_en,
    input wire cmb_pkg::cmb_rx_wr_t eng_rx_wr,
    input wire cmb_pkg::cmb_rx_end_t eng_rx_end,
    input wire cmb_pkg::cmb_tx_evt_t eng_tx_evt,
    input wire logic [3:0] eng_tx_rd_idx,
    output logic [7:0] eng_tx_rd_data,
    output logic eng_tx_req,
    output logic [1:0] eng_tx_sel,
    output logic rx_irq,
    output logic tx_irq,
    output logic err_irq
);
    import cmb_pkg::*;

    // ----------------------------------------------------------------
    // reset and pin synchronisers
    // ----------------------------------------------------------------
    logic rst_meta_ff, rst_sync_ff;
    logic rx_meta_ff, rx_sync_ff;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            rx_meta_ff <= CMB_RECESSIVE;
            rx_sync_ff <= CMB_RECESSIVE;
        end else begin
            rx_meta_ff <= bus_rx_pin;
            rx_sync_ff <= rx_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] rx_background_buffer [CMB_MSG_BYTES];
    logic [7:0] rx_foreground_buffer [CMB_MSG_BYTES];
    logic [7:0] tx_buf [CMB_TX_BUFS][CMB_MSG_BYTES];
    logic [7:0] tx_priority_reg [CMB_TX_BUFS];
    logic rx_full_flag_ff, bg_held_ff, ovr_flag_ff;
    logic rxf_ie_ff, ovr_ie_ff, loopback_ff, lowpwr_ff;
    logic [2:0] tx_empty_flag_ff, abort_acknowledge_ff, abort_request_ff, txe_ie_ff;
    logic tx_busy_ff;
    logic [1:0] tx_sel_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic tx_pin_ff, eng_rx_bit_ff, ack_en_ff, tx_req_ff;
    logic [7:0] tx_rd_data_ff;
    logic rx_irq_ff, tx_irq_ff, err_irq_ff;

    // ----------------------------------------------------------------
    // bus decode: one wait cycle, then a one-cycle answer
    // ----------------------------------------------------------------
    wire req = avs_read | avs_write;
    wire wr_acc = avs_write & ~wait_ff & avs_byteenable[0];
    wire [2:0] win = avs_address[8:6];
    wire [3:0] bidx = avs_address[5:2];
    wire [8:0] word_ofs = {avs_address[8:2], 2'b00};
    wire in_regs = (win == CMB_WIN_REGS);
    wire in_rxwin = (win == CMB_WIN_RX_FG) && (bidx < 4'(CMB_MSG_BYTES));
    wire [2:0] tx_win = win - CMB_WIN_TX0;
    wire in_txwin = (win >= CMB_WIN_TX0) && (tx_win < 3'(CMB_TX_BUFS)) && (bidx < 4'(CMB_MSG_BYTES));
    wire [1:0] tx_k = tx_win[1:0];
    wire [7:0] wbyte = avs_writedata[7:0];
    wire wr_rx_flag = wr_acc && in_regs && (word_ofs == CMB_OFS_RX_FLAG);
    wire wr_rx_mask = wr_acc && in_regs && (word_ofs == CMB_OFS_RX_MASK);
    wire wr_tx_flag = wr_acc && in_regs && (word_ofs == CMB_OFS_TX_FLAG);
    wire wr_tx_ctrl = wr_acc && in_regs && (word_ofs == CMB_OFS_TX_CTRL);
    wire wr_mod_ctrl = wr_acc && in_regs && (word_ofs == CMB_OFS_MOD_CTRL);
    wire wr_local_priority_field = wr_acc && in_regs && (word_ofs >= CMB_OFS_PRIO0) && (word_ofs <= CMB_OFS_PRIO2);
    wire [1:0] local_priority_field_k = 2'(word_ofs[4:2] - CMB_OFS_PRIO0[4:2]);
    wire wr_txbuf = wr_acc && in_txwin;

    // ----------------------------------------------------------------
    // receive path
    // ----------------------------------------------------------------
    // own frame only counts as received in loop-back
    wire own_rx = tx_busy_ff & ~loopback_ff;
    wire done_ok = eng_rx_end.eof_ok & eng_rx_end.accept & ~own_rx;
    // write one clears, but a held frame refills at once
    wire rxf_clr = wr_rx_flag & wbyte[CMB_BIT_RXF];
    // copy only into a free foreground buffer
    wire copy_new = done_ok & ~bg_held_ff & (~rx_full_flag_ff | rxf_clr);
    wire copy_held = bg_held_ff & (rxf_clr | ~rx_full_flag_ff);
    wire ovr_evt = done_ok & bg_held_ff;
    // background overwritten unless both stages are occupied
    wire bg_we = eng_rx_wr.we & ~bg_held_ff & (eng_rx_wr.idx < 4'(CMB_MSG_BYTES));
    wire nxt_rxf = copy_new | copy_held | (rx_full_flag_ff & ~rxf_clr);
    wire nxt_bg_held = (bg_held_ff & ~copy_held) | (done_ok & ~copy_new & ~bg_held_ff);
    wire nxt_ovr = ovr_evt | (ovr_flag_ff & ~(wr_rx_flag & wbyte[CMB_BIT_OVR]));

    // background stage, filled byte by byte by the engine
    always_ff @(posedge ref_clk) begin
        if (bg_we) begin
            rx_background_buffer[eng_rx_wr.idx] <= eng_rx_wr.data;
        end
    end

    // foreground stage takes the whole frame in one cycle
    always_ff @(posedge ref_clk) begin
        if (copy_new | copy_held) begin
            rx_foreground_buffer <= rx_background_buffer;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            rx_full_flag_ff <= 1'b0;
            bg_held_ff <= 1'b0;
            ovr_flag_ff <= 1'b0;
        end else begin
            rx_full_flag_ff <= nxt_rxf;
            bg_held_ff <= nxt_bg_held;
            ovr_flag_ff <= nxt_ovr;
        end
    end

    // ----------------------------------------------------------------
    // transmit buffers and scheduler
    // ----------------------------------------------------------------
    // smallest value wins, strict compare keeps lowest index on ties
    function automatic logic [1:0] pick_buf(input logic [2:0] rdy, input logic [7:0] p0,
                                            input logic [7:0] p1, input logic [7:0] p2);
        logic [1:0] best;
        logic [7:0] bp;
        best = 2'd0;
        bp = p0;
        if (!rdy[0] || (rdy[1] && p1 < bp)) begin
            best = 2'd1;
            bp = p1;
        end
        if (rdy[2] && (!rdy[best] || p2 < bp)) begin
            best = 2'd2;
        end
        return best;
    endfunction

    wire [2:0] tx_ready = ~tx_empty_flag_ff;
    wire [1:0] pick = pick_buf(tx_ready, tx_priority_reg[0], tx_priority_reg[1], tx_priority_reg[2]);
    // choose afresh at every arbitration start
    wire sched = eng_tx_evt.arb_start & ~tx_busy_ff & (|tx_ready) & ~lowpwr_ff;
    wire [2:0] sel_hot = 3'b001 << tx_sel_ff;
    // successful send frees the active buffer
    wire [2:0] done_set = (eng_tx_evt.done & tx_busy_ff) ? sel_hot : 3'b000;
    // a pending buffer may be aborted, the active one may not
    wire [2:0] abort_set = abort_request_ff & tx_ready & ~(tx_busy_ff ? sel_hot : 3'b000);
    // software marks ready by clearing empty; hardware set wins
    wire [2:0] empty_clr = wr_tx_flag ? wbyte[2:0] : 3'b000;
    wire [2:0] nxt_empty = (tx_empty_flag_ff & ~empty_clr) | done_set | abort_set;
    wire [2:0] nxt_ack = ((abort_acknowledge_ff & ~empty_clr) | abort_set) & ~done_set;
    wire [2:0] nxt_abreq = (wr_tx_ctrl ? wbyte[2:0] : abort_request_ff) & ~nxt_empty;
    // lost arbitration or error drops back to receiving
    wire tx_end = eng_tx_evt.done | eng_tx_evt.err | eng_tx_evt.arb_lost;

    // software loads the three transmit buffers
    always_ff @(posedge ref_clk) begin
        if (wr_txbuf) begin
            tx_buf[tx_k][bidx] <= wbyte;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            tx_priority_reg <= '{default: CMB_RST_LOCAL_PRIORITY_FIELD};
        end else if (wr_local_priority_field) begin
            tx_priority_reg[local_priority_field_k] <= wbyte;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            tx_empty_flag_ff <= CMB_RST_TX_EMPTY;
            abort_acknowledge_ff <= 3'h0;
            abort_request_ff <= 3'h0;
        end else begin
            tx_empty_flag_ff <= nxt_empty;
            abort_acknowledge_ff <= nxt_ack;
            abort_request_ff <= nxt_abreq;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            tx_busy_ff <= 1'b0;
            tx_sel_ff <= 2'd0;
        end else if (sched) begin
            tx_busy_ff <= 1'b1;
            tx_sel_ff <= pick;
        end else if (tx_end) begin
            tx_busy_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            rxf_ie_ff <= 1'b0;
            ovr_ie_ff <= 1'b0;
            txe_ie_ff <= 3'h0;
            loopback_ff <= 1'b0;
            lowpwr_ff <= 1'b0;
        end else begin
            if (wr_rx_mask) begin
                rxf_ie_ff <= wbyte[CMB_BIT_RXF];
                ovr_ie_ff <= wbyte[CMB_BIT_OVR];
            end
            if (wr_tx_ctrl) begin
                txe_ie_ff <= wbyte[CMB_FLD_TXIE_LO +: 3];
            end
            if (wr_mod_ctrl) begin
                loopback_ff <= wbyte[CMB_BIT_LOOP];
                lowpwr_ff <= wbyte[CMB_BIT_LOWPWR];
            end
        end
    end

    // ----------------------------------------------------------------
    // read mux; unmapped addresses read zero
    // ----------------------------------------------------------------
    wire [7:0] reg_byte =
        (word_ofs == CMB_OFS_RX_FLAG) ? {6'h0, ovr_flag_ff, rx_full_flag_ff} :
        (word_ofs == CMB_OFS_RX_MASK) ? {6'h0, ovr_ie_ff, rxf_ie_ff} :
        (word_ofs == CMB_OFS_TX_FLAG) ? {1'b0, abort_acknowledge_ff, 1'b0, tx_empty_flag_ff} :
        (word_ofs == CMB_OFS_TX_CTRL) ? {1'b0, txe_ie_ff, 1'b0, abort_request_ff} :
        (word_ofs == CMB_OFS_MOD_CTRL) ? {6'h0, lowpwr_ff, loopback_ff} :
        (word_ofs == CMB_OFS_PRIO0) ? tx_priority_reg[0] :
        (word_ofs == CMB_OFS_PRIO1) ? tx_priority_reg[1] :
        (word_ofs == CMB_OFS_PRIO2) ? tx_priority_reg[2] :
        (word_ofs == CMB_OFS_STATUS) ? {4'h0, bg_held_ff, tx_sel_ff, tx_busy_ff} : 8'h00;
    wire [7:0] rd_byte = in_regs ? reg_byte :
                         in_rxwin ? rx_foreground_buffer[bidx] :
                         in_txwin ? tx_buf[tx_k][bidx] : 8'h00;

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wait_ff <= ~(req & wait_ff);
            if (avs_read & wait_ff) begin
                rdata_ff <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ----------------------------------------------------------------
    // engine side and pins
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            tx_pin_ff <= CMB_RECESSIVE;
            eng_rx_bit_ff <= CMB_RECESSIVE;
            ack_en_ff <= 1'b1;
            tx_req_ff <= 1'b0;
            tx_rd_data_ff <= 8'h00;
        end else begin
            // engine bit passes as-is, forced recessive when powered down
            tx_pin_ff <= lowpwr_ff ? CMB_RECESSIVE : eng_tx_bit;
            // loop-back feeds own bits back to the receiver
            eng_rx_bit_ff <= loopback_ff ? eng_tx_bit : rx_sync_ff;
            // no acknowledge of own frame except in loop-back
            ack_en_ff <= ~own_rx;
            tx_req_ff <= (|tx_ready) & ~lowpwr_ff;
            tx_rd_data_ff <= tx_buf[tx_sel_ff][eng_tx_rd_idx];
        end
    end

    // interrupt lines are plain flag-and-mask levels, no separate controller
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            rx_irq_ff <= 1'b0;
            tx_irq_ff <= 1'b0;
            err_irq_ff <= 1'b0;
        end else begin
            // raised the cycle after the frame is taken
            rx_irq_ff <= nxt_rxf & rxf_ie_ff;
            tx_irq_ff <= |(nxt_empty & txe_ie_ff);
            err_irq_ff <= nxt_ovr & ovr_ie_ff;
        end
    end

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign bus_tx_pin = tx_pin_ff;
    assign eng_rx_bit = eng_rx_bit_ff;
    assign eng_ack_en = ack_en_ff;
    assign eng_tx_req = tx_req_ff;
    assign eng_tx_sel = tx_sel_ff;
    assign eng_tx_rd_data = tx_rd_data_ff;
    assign rx_irq = rx_irq_ff;
    assign tx_irq = tx_irq_ff;
    assign err_irq = err_irq_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_lowpwr_recessive: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        lowpwr_ff ##1 lowpwr_ff |-> bus_tx_pin == CMB_RECESSIVE)
        else $error("tx pin not recessive in low power");

    chk_rx_copy_flag: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        eng_rx_end.eof_ok && eng_rx_end.accept && !own_rx && !rx_full_flag_ff && !bg_held_ff
        |=> rx_full_flag_ff && rx_irq == $past(rxf_ie_ff))
        else $error("accepted frame did not set full flag and interrupt");

    chk_own_frame_quiet: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        tx_busy_ff && !loopback_ff && !rx_full_flag_ff && !bg_held_ff |=> !rx_full_flag_ff)
        else $error("own frame reached foreground buffer");

    chk_overrun_set: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        eng_rx_end.eof_ok && eng_rx_end.accept && !own_rx && bg_held_ff
        |=> ovr_flag_ff && rx_full_flag_ff && $stable(rx_foreground_buffer[0]))
        else $error("overrun not flagged or foreground disturbed");

    chk_rxf_refuse_clr: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        bg_held_ff && rxf_clr |=> rx_full_flag_ff && !bg_held_ff)
        else $error("full flag cleared while a frame was waiting");

    chk_sent_empty: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        eng_tx_evt.done && tx_busy_ff |=> tx_empty_flag_ff[$past(tx_sel_ff)]
        && !abort_acknowledge_ff[$past(tx_sel_ff)] && !tx_busy_ff)
        else $error("sent buffer not released or shows abort");

    chk_abort_active: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        tx_busy_ff && abort_request_ff[tx_sel_ff] && !eng_tx_evt.done
        |=> !tx_empty_flag_ff[$past(tx_sel_ff)] || $past(empty_clr) != 3'h0)
        else $error("buffer under transmission was aborted");

    chk_abort_grant: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        abort_set != 3'h0 |=> (abort_acknowledge_ff & $past(abort_set)) == $past(abort_set)
        && (tx_empty_flag_ff & $past(abort_set)) == $past(abort_set))
        else $error("abort not acknowledged");

    chk_sched_local_priority_field: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        sched |=> tx_busy_ff ##0 (!$past(tx_ready[0]) || tx_priority_reg[tx_sel_ff] <= tx_priority_reg[0])
        && (!$past(tx_ready[1]) || tx_priority_reg[tx_sel_ff] <= tx_priority_reg[1])
        && (!$past(tx_ready[2]) || tx_priority_reg[tx_sel_ff] <= tx_priority_reg[2]))
        else $error("scheduled buffer is not the highest priority");

    chk_bus_answer: assert property (@(posedge ref_clk) disable iff (!rst_sync_ff)
        req && wait_ff |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");

endmodule

// ===== rtl/cmb_pkg.sv
// shared constants and carrier types for the CAN message buffering block
package cmb_pkg;

    // ----------------------------------------------------------------
    // buffer geometry
    // ----------------------------------------------------------------
    localparam int CMB_MSG_BYTES = 13;
    localparam int CMB_TX_BUFS = 3;
    localparam int CMB_LOCAL_PRIORITY_FIELD_W = 8;
    localparam int CMB_ADDR_W = 9;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [8:0] CMB_OFS_RX_FLAG = 9'h000;
    localparam logic [8:0] CMB_OFS_RX_MASK = 9'h004;
    localparam logic [8:0] CMB_OFS_TX_FLAG = 9'h008;
    localparam logic [8:0] CMB_OFS_TX_CTRL = 9'h00C;
    localparam logic [8:0] CMB_OFS_MOD_CTRL = 9'h010;
    localparam logic [8:0] CMB_OFS_PRIO0 = 9'h014;
    localparam logic [8:0] CMB_OFS_PRIO1 = 9'h018;
    localparam logic [8:0] CMB_OFS_PRIO2 = 9'h01C;
    localparam logic [8:0] CMB_OFS_STATUS = 9'h020;
    // windows selected by address bits 8:6; byte index in bits 5:2
    localparam logic [2:0] CMB_WIN_REGS = 3'h0;
    localparam logic [2:0] CMB_WIN_RX_FG = 3'h1;
    localparam logic [2:0] CMB_WIN_TX0 = 3'h2;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CMB_BIT_RXF = 0;
    localparam int CMB_BIT_OVR = 1;
    localparam int CMB_BIT_LOOP = 0;
    localparam int CMB_BIT_LOWPWR = 1;
    localparam int CMB_FLD_ACK_LO = 4;
    localparam int CMB_FLD_TXIE_LO = 4;

    // ----------------------------------------------------------------
    // reset values and bus levels
    // ----------------------------------------------------------------
    localparam logic [2:0] CMB_RST_TX_EMPTY = 3'h7;
    localparam logic [7:0] CMB_RST_LOCAL_PRIORITY_FIELD = 8'h00;
    localparam logic CMB_RECESSIVE = 1'b1;
    localparam logic CMB_DOMINANT = 1'b0;

    // ----------------------------------------------------------------
    // carriers between protocol engine and buffers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic we;
        logic [3:0] idx;
        logic [7:0] data;
    } cmb_rx_wr_t;

    typedef struct packed {
        logic eof_ok;
        logic accept;
    } cmb_rx_end_t;

    typedef struct packed {
        logic arb_start;
        logic done;
        logic err;
        logic arb_lost;
    } cmb_tx_evt_t;

endpackage

// ===== tb/cmb_partner.sv
// transceiver model: wired bus of this node and one other node
`timescale 1ns/100ps
module cmb_partner (
    input wire logic tx_pin,
    input wire logic other_dom,
    output logic rx_pin
);
    assign rx_pin = tx_pin & ~other_dom;
endmodule

// ===== tb/testbench.sv
// self-checking bench for the message buffering block
`timescale 1ns/100ps
module testbench;
    import cmb_pkg::*;
    logic ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest, bus_rx_pin, bus_tx_pin;
    logic eng_rx_bit, eng_ack_en, eng_tx_req, rx_irq, tx_irq, err_irq;
    logic [8:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic [7:0] eng_tx_rd_data;
    logic eng_tx_bit = 1'b1, other_dom = 1'b0;
    logic [3:0] eng_tx_rd_idx = '0;
    logic [1:0] eng_tx_sel;
    cmb_rx_wr_t eng_rx_wr = '0;
    cmb_rx_end_t eng_rx_end = '0;
    cmb_tx_evt_t eng_tx_evt = '0;
    int n_errors = 0, tests_run = 0, cyc = 0;
    always #2 ref_clk = ~ref_clk;
    cmb_partner bus (.tx_pin(bus_tx_pin), .other_dom(other_dom), .rx_pin(bus_rx_pin));
    cmb_msg_buf uut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus_rx_pin(bus_rx_pin),
        .bus_tx_pin(bus_tx_pin), .eng_tx_bit(eng_tx_bit), .eng_rx_bit(eng_rx_bit), .eng_ack_en(eng_ack_en),
        .eng_rx_wr(eng_rx_wr), .eng_rx_end(eng_rx_end), .eng_tx_evt(eng_tx_evt), .eng_tx_rd_idx(eng_tx_rd_idx),
        .eng_tx_rd_data(eng_tx_rd_data), .eng_tx_req(eng_tx_req), .eng_tx_sel(eng_tx_sel),
        .rx_irq(rx_irq), .tx_irq(tx_irq), .err_irq(err_irq));
    task automatic finish_test();
        $display("errors %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // hang guard, a few thousand cycles beyond the expected run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until waitrequest seen low at a rising edge
    task automatic bus_op(input logic wr, input logic [8:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        bus_op(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask
    task automatic rx_frame(input logic [7:0] b, input logic acc);
        for (int i = 0; i < 13; i++) begin
            eng_rx_wr <= '{we: 1'b1, idx: i[3:0], data: b + i[7:0]};
            @(posedge ref_clk);
        end
        eng_rx_wr <= '0;
        eng_rx_end <= '{eof_ok: 1'b1, accept: acc};
        @(posedge ref_clk);
        eng_rx_end <= '0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic tx_pulse(input cmb_tx_evt_t e);
        eng_tx_evt <= e;
        @(posedge ref_clk);
        eng_tx_evt <= '0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic t_reset();
        chk(bus_tx_pin, CMB_RECESSIVE);
        rd(CMB_OFS_TX_FLAG, 8'h07);
    endtask
    task automatic t_pins();
        eng_tx_bit <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(bus_tx_pin, CMB_DOMINANT);
        eng_tx_bit <= 1'b1;
        other_dom <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(eng_rx_bit, CMB_DOMINANT);
        bus_op(1'b1, CMB_OFS_MOD_CTRL, 8'h01);
        @(posedge ref_clk);
        chk(eng_rx_bit, CMB_RECESSIVE);
        other_dom <= 1'b0;
        bus_op(1'b1, CMB_OFS_MOD_CTRL, 8'h00);
    endtask
    task automatic t_rx();
        bus_op(1'b1, CMB_OFS_RX_MASK, 8'h03);
        rx_frame(8'h10, 1'b1);
        chk(rx_irq, 1'b1);
        rd(CMB_OFS_RX_FLAG, 8'h01);
        rd(9'h040 + 9'd48, 8'h1C);
        rx_frame(8'h40, 1'b0);
        rd(9'h054, 8'h15);
        rx_frame(8'h60, 1'b1);
        rd(9'h040, 8'h10);
        rx_frame(8'h80, 1'b1);
        chk(err_irq, 1'b1);
        bus_op(1'b1, CMB_OFS_RX_FLAG, 8'h01);
        rd(CMB_OFS_RX_FLAG, 8'h03);
        rd(9'h040, 8'h60);
    endtask
    task automatic t_tx();
        bus_op(1'b1, CMB_OFS_PRIO0, 8'h05);
        bus_op(1'b1, CMB_OFS_PRIO1, 8'h03);
        bus_op(1'b1, CMB_OFS_PRIO2, 8'h03);
        rd(CMB_OFS_PRIO2, 8'h03);
        bus_op(1'b1, 9'h088, 8'h5A);
        bus_op(1'b1, CMB_OFS_TX_CTRL, 8'h70);
        bus_op(1'b1, CMB_OFS_TX_FLAG, 8'h07);
        // request flop follows the empty flags one cycle later
        @(posedge ref_clk);
        chk(eng_tx_req, 1'b1);
        tx_pulse('{arb_start: 1'b1, default: 1'b0});
        chk(eng_tx_sel, 2'h1);
        chk(eng_ack_en, 1'b0);
        bus_op(1'b1, CMB_OFS_RX_FLAG, 8'h03);
        rx_frame(8'hA0, 1'b1);
        rd(CMB_OFS_RX_FLAG, 8'h00);
        // only buffer 1 may interrupt, so the abort of buffer 0 stays quiet
        bus_op(1'b1, CMB_OFS_TX_CTRL, 8'h23);
        rd(CMB_OFS_TX_FLAG, 8'h11);
        tx_pulse('{done: 1'b1, default: 1'b0});
        rd(CMB_OFS_TX_FLAG, 8'h13);
        chk(tx_irq, 1'b1);
        tx_pulse('{arb_start: 1'b1, default: 1'b0});
        tx_pulse('{err: 1'b1, default: 1'b0});
        bus_op(1'b1, CMB_OFS_PRIO0, 8'h01);
        bus_op(1'b1, CMB_OFS_TX_FLAG, 8'h01);
        tx_pulse('{arb_start: 1'b1, default: 1'b0});
        chk(eng_tx_sel, 2'h0);
        eng_tx_rd_idx <= 4'h2;
        repeat (2) @(posedge ref_clk);
        chk(eng_tx_rd_data, 8'h5A);
        tx_pulse('{arb_lost: 1'b1, default: 1'b0});
        rx_frame(8'hC0, 1'b1);
        rd(CMB_OFS_RX_FLAG, 8'h01);
        bus_op(1'b1, CMB_OFS_MOD_CTRL, 8'h01);
        bus_op(1'b1, CMB_OFS_RX_FLAG, 8'h01);
        tx_pulse('{arb_start: 1'b1, default: 1'b0});
        chk(eng_ack_en, 1'b1);
        rx_frame(8'hE0, 1'b1);
        rd(9'h040, 8'hE0);
        eng_tx_bit <= 1'b0;
        bus_op(1'b1, CMB_OFS_MOD_CTRL, 8'h02);
        @(posedge ref_clk);
        chk(bus_tx_pin, CMB_RECESSIVE);
        chk(eng_tx_req, 1'b0);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_pins();
        t_rx();
        t_tx();
        finish_test();
    end
endmodule
